// ===== shared/pci_arb_cfg.svh
/*
 * Constants for the PCI arbiter and hold control block: widths,
 * reset values and synchroniser depth.
 * Assumes it is included by bare name after the package.
 */
`ifndef PCI_ARB_CFG_SVH
`define PCI_ARB_CFG_SVH

// number of PCI masters served by the arbiter
`define ARB_MASTERS 5
// address/data and command/byte-enable widths
`define ARB_AD_WIDTH 32
`define ARB_CBE_WIDTH 4
// reset value of the grant lines, all negated
`define ARB_GNT_RESET 5'h1F
// reset value of the last granted master pointer
`define ARB_LAST_RESET 3'h4
// flops between a pin and the first logic reading it
`define ARB_SYNC_STAGES 2
// clock-run sync value in reset: pin seen low, clock running
`define ARB_CLKRUN_SYNC_RESET 1'h0

`endif

// ===== shared/pci_arb_pkg.sv
/*
 * Types shared by the PCI arbiter and hold control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pci_arb_pkg;

	// hold handshake sequence with the expansion bridge
	typedef enum logic [2:0] {
		HOLD_IDLE,
		HOLD_DRAIN_WR,
		HOLD_DRAIN_POST,
		HOLD_ACQ_HOST,
		HOLD_GRANTED
	} holdState_type;

endpackage

// ===== logic/pci_parity_gen.sv
/*
 * Even parity over the address/data and command/byte-enable lines.
 * Assumes the caller registers the result for the next clock.
 */
`timescale 1ns/1ps

module pci_parity_gen #(
	parameter int AD_WIDTH = 32,
	parameter int CBE_WIDTH = 4
) (
	// covered lines
	input wire logic [AD_WIDTH-1:0] adBus,
	input wire logic [CBE_WIDTH-1:0] cbeBusN,
	// one parity bit
	output logic parity
);

	// xor of all covered lines gives even parity
	assign parity = ^{adBus, cbeBusN};

endmodule

// ===== logic/pci_arbiter_hold_control.sv
/*
 * PCI-side control of a host bridge: five-master arbiter, hold handshake
 * with an expansion bridge, parity, system error and clock-run.
 * Assumes one PCI clock mclk; request pins are asynchronous and are
 * synchronised here; buffer and host bus status come from the same clock.
 */
`timescale 1ns/1ps
`include "pci_arb_cfg.svh"

module pci_arbiter_hold_control
	import pci_arb_pkg::*;
#(
	parameter int MASTERS = `ARB_MASTERS,
	parameter int AD_WIDTH = `ARB_AD_WIDTH,
	parameter int CBE_WIDTH = `ARB_CBE_WIDTH
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// master arbitration pins
	input wire logic [MASTERS-1:0] reqN,
	output logic [MASTERS-1:0] gntN,
	output logic gntOe,
	// expansion bridge hold handshake
	input wire logic bridge_hold_request_n,
	output logic bridge_hold_ack_n,
	output logic holdAckOe,
	// buffer drain and host bus side
	input wire logic writeBufEmpty,
	input wire logic postBufEmpty,
	input wire logic hostBusGranted,
	output logic drainWriteReq,
	output logic drainPostReq,
	output logic hostBusReq,
	// parity from the outgoing datapath
	input wire logic [AD_WIDTH-1:0] adOut,
	input wire logic [CBE_WIDTH-1:0] cbeOutN,
	input wire logic parDrive,
	output logic parOut,
	output logic parOe,
	// system error
	input wire logic errorEvent,
	output logic serrOutN,
	output logic serrOe,
	// clock-run open-drain pin
	input wire logic clkrunIn,
	input wire logic keepClock,
	output logic clkrunOut,
	output logic clkrunOe,
	output logic clkrunSeen
);

	localparam int PTR_W = $clog2(MASTERS);
	localparam int SYNC_W = MASTERS + 2;
	localparam logic [SYNC_W-1:0] SYNC_RESET =
		{`ARB_CLKRUN_SYNC_RESET, {(MASTERS+1){1'b1}}};

	////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [SYNC_W-1:0] syncMeta_q;
	logic [SYNC_W-1:0] syncPin_q;
	wire [SYNC_W-1:0] pinRaw = {clkrunIn, bridge_hold_request_n, reqN};

	// two flops before any logic reads a pin
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncMeta_q <= SYNC_RESET;
			syncPin_q <= SYNC_RESET;
		end
		else
		begin
			syncMeta_q <= pinRaw;
			syncPin_q <= syncMeta_q;
		end
	end

	wire [MASTERS-1:0] masterReq = ~syncPin_q[MASTERS-1:0];
	wire bridgeReq = ~syncPin_q[MASTERS];
	wire clkrunHigh = syncPin_q[MASTERS+1];

	////////////////////////////////////////////////////////////////////
	// hold sequence with the expansion bridge
	holdState_type holdState_q;
	holdState_type holdState_d;
	logic [MASTERS-1:0] gntN_q;
	wire grantsIdle = (gntN_q == `ARB_GNT_RESET);

	// drain, drain, acquire, then acknowledge; a dropped request aborts
	always_comb
	begin
		holdState_d = holdState_q;
		unique case (holdState_q)
			HOLD_IDLE:
				if (bridgeReq)
					holdState_d = HOLD_DRAIN_WR;
			HOLD_DRAIN_WR:
				if (!bridgeReq)
					holdState_d = HOLD_IDLE;
				else if (writeBufEmpty)
					holdState_d = HOLD_DRAIN_POST;
			HOLD_DRAIN_POST:
				if (!bridgeReq)
					holdState_d = HOLD_IDLE;
				else if (postBufEmpty)
					holdState_d = HOLD_ACQ_HOST;
			HOLD_ACQ_HOST:
				if (!bridgeReq)
					holdState_d = HOLD_IDLE;
				else if (hostBusGranted && grantsIdle)
					holdState_d = HOLD_GRANTED;
			HOLD_GRANTED:
				if (!bridgeReq)
					holdState_d = HOLD_IDLE;
		endcase
	end

	logic holdAckN_q;
	logic drainWr_q;
	logic drainPost_q;
	logic hostReq_q;
	wire holdPending = (holdState_d != HOLD_IDLE);

	// state and handshake flops
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			holdState_q <= HOLD_IDLE;
			holdAckN_q <= 1'b1;
			drainWr_q <= 1'b0;
			drainPost_q <= 1'b0;
			hostReq_q <= 1'b0;
		end
		else
		begin
			holdState_q <= holdState_d;
			holdAckN_q <= (holdState_d != HOLD_GRANTED);
			drainWr_q <= (holdState_d == HOLD_DRAIN_WR);
			drainPost_q <= (holdState_d == HOLD_DRAIN_POST);
			hostReq_q <= (holdState_d == HOLD_ACQ_HOST)
				|| (holdState_d == HOLD_GRANTED);
		end
	end

	////////////////////////////////////////////////////////////////////
	// round-robin master arbiter
	logic [PTR_W-1:0] last_q;
	logic [MASTERS-1:0] pick;
	logic [PTR_W-1:0] pickIdx;
	logic pickAny;

	// first requester after the last one granted
	always_comb
	begin
		int idx;
		idx = 0;
		pick = '0;
		pickIdx = '0;
		pickAny = 1'b0;
		for (int k = MASTERS; k >= 1; k--)
		begin
			idx = (int'(last_q) + k) % MASTERS;
			if (masterReq[idx])
			begin
				pickIdx = PTR_W'(idx);
				pickAny = 1'b1;
			end
		end
		if (pickAny)
			pick[pickIdx] = 1'b1;
	end

	wire [MASTERS-1:0] curGnt = ~gntN_q;
	wire ownerKeeps = |(curGnt & masterReq);
	wire newGrant = grantsIdle && pickAny && !holdPending
		&& holdAckN_q;

	// one idle cycle between owners; hold pending takes grants away
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gntN_q <= `ARB_GNT_RESET;
			last_q <= `ARB_LAST_RESET;
		end
		else if (newGrant)
		begin
			gntN_q <= ~pick;
			last_q <= pickIdx;
		end
		else if (!grantsIdle && (holdPending || !ownerKeeps))
			gntN_q <= `ARB_GNT_RESET;
	end

	////////////////////////////////////////////////////////////////////
	// parity, system error and clock-run
	wire parNow;
	pci_parity_gen #(
		.AD_WIDTH(AD_WIDTH),
		.CBE_WIDTH(CBE_WIDTH)
	) parityGen (
		.adBus(adOut),
		.cbeBusN(cbeOutN),
		.parity(parNow)
	);
	logic parOut_q;
	logic parOe_q;
	logic serrOe_q;
	logic clkrunOe_q;
	logic drivesOn_q;

	// parity one clock after its data; open-drain pins pull low only
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			parOut_q <= 1'b0;
			parOe_q <= 1'b0;
			serrOe_q <= 1'b0;
			clkrunOe_q <= 1'b0;
			drivesOn_q <= 1'b0;
		end
		else
		begin
			parOut_q <= parNow;
			parOe_q <= parDrive;
			serrOe_q <= errorEvent;
			clkrunOe_q <= keepClock && clkrunHigh;
			drivesOn_q <= 1'b1;
		end
	end

	assign gntN = gntN_q;
	assign gntOe = drivesOn_q;
	assign bridge_hold_ack_n = holdAckN_q;
	assign holdAckOe = drivesOn_q;
	assign drainWriteReq = drainWr_q;
	assign drainPostReq = drainPost_q;
	assign hostBusReq = hostReq_q;
	assign parOut = parOut_q;
	assign parOe = parOe_q;
	assign serrOutN = 1'b0;
	assign serrOe = serrOe_q;
	assign clkrunOut = 1'b0;
	assign clkrunOe = clkrunOe_q;
	assign clkrunSeen = ~clkrunHigh;

	////////////////////////////////////////////////////////////////////
	// checks
	grant_onehot_a: assert property (
		@(posedge mclk) disable iff (!rst_n) $onehot0(~gntN_q))
		else $error("more than one master grant");
	grant_vs_hold_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!holdAckN_q |-> gntN_q == `ARB_GNT_RESET)
		else $error("master grant during hold acknowledge");
	ack_after_host_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		$fell(holdAckN_q) |-> $past(hostReq_q) && $past(hostBusGranted))
		else $error("hold acknowledged before host bus taken");
	drain_order_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		$rose(drainPost_q) |-> $past(drainWr_q) && $past(writeBufEmpty))
		else $error("posted drain before write drain done");
	release_ack_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(!holdAckN_q && !bridgeReq) |=> holdAckN_q)
		else $error("acknowledge held after release");
	parity_value_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		##1 parOut_q == $past(^{adOut, cbeOutN}))
		else $error("parity mismatch");
	serr_pulse_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		errorEvent |=> serrOe_q && !serrOutN)
		else $error("system error not driven");
	clkrun_cause_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		clkrunOe_q |-> $past(keepClock) && $past(clkrunHigh))
		else $error("clock-run driven without cause");
	grant_idle_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(!grantsIdle && $changed(gntN_q)) |-> $past(grantsIdle))
		else $error("grant moved without idle cycle");

endmodule

// ===== bench/far_side_model.sv
/* buffers, host bus and clock-run pull-up beside the block.
   assumes the block's mclk and rst_n. */
`timescale 1ns/1ps

module far_side_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// drain and host bus handshake
	input wire logic [3:0] lat,
	input wire logic drainWriteReq,
	input wire logic drainPostReq,
	input wire logic hostBusReq,
	output logic writeBufEmpty,
	output logic postBufEmpty,
	output logic hostBusGranted,
	// clock-run wire
	input wire logic clkrunOe,
	input wire logic clkrunOut,
	input wire logic centralLow,
	output logic clkrunIn
);
	logic [3:0] wCnt_q, pCnt_q, hCnt_q;

	// each answer comes lat cycles after its request
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			wCnt_q <= 4'h0;
			pCnt_q <= 4'h0;
			hCnt_q <= 4'h0;
		end
		else
		begin
			wCnt_q <= drainWriteReq ? wCnt_q - 4'(wCnt_q != 0) : lat;
			pCnt_q <= drainPostReq ? pCnt_q - 4'(pCnt_q != 0) : lat;
			hCnt_q <= hostBusReq ? hCnt_q - 4'(hCnt_q != 0) : lat;
		end

	// status only while asked for
	assign writeBufEmpty = drainWriteReq && wCnt_q == 4'h0;
	assign postBufEmpty = drainPostReq && pCnt_q == 4'h0;
	assign hostBusGranted = hostBusReq && hCnt_q == 4'h0;
	// pulled up unless someone pulls low
	assign clkrunIn = !((clkrunOe && !clkrunOut) || centralLow);
endmodule

// ===== bench/tb.sv
/* self-checking bench for the arbiter and hold control.
   assumes far_side_model answers drains and host bus. */
`timescale 1ns/1ps

module tb;
	logic mclk, rst_n, bridge_hold_request_n, bridge_hold_ack_n;
	logic holdAckOe, gntOe, parDrive, parOut, parOe, errorEvent;
	logic serrOutN, serrOe, clkrunIn, keepClock, clkrunOut, clkrunOe;
	logic clkrunSeen, writeBufEmpty, postBufEmpty, hostBusGranted;
	logic drainWriteReq, drainPostReq, hostBusReq, centralLow;
	logic [4:0] reqN, gntN;
	logic [31:0] adOut;
	logic [3:0] cbeOutN, lat;
	int err_count, comparisons;

	pci_arbiter_hold_control dut (.mclk, .rst_n, .reqN, .gntN, .gntOe,
		.bridge_hold_request_n, .bridge_hold_ack_n, .holdAckOe,
		.writeBufEmpty, .postBufEmpty, .hostBusGranted, .drainWriteReq,
		.drainPostReq, .hostBusReq, .adOut, .cbeOutN, .parDrive, .parOut,
		.parOe, .errorEvent, .serrOutN, .serrOe, .clkrunIn, .keepClock,
		.clkrunOut, .clkrunOe, .clkrunSeen);
	far_side_model far (.mclk, .rst_n, .lat, .drainWriteReq,
		.drainPostReq, .hostBusReq, .writeBufEmpty, .postBufEmpty,
		.hostBusGranted, .clkrunOe, .clkrunOut, .centralLow, .clkrunIn);

	////////////////////////////////////////////////////////////////////
	// clock and watchdog
	initial
	begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	initial
	begin
		#(3000 * 25);
		err_count++;
		report_and_stop;
	end

	////////////////////////////////////////////////////////////////////
	task report_and_stop;
		if (err_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task check(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp)
			$display("Error %s expected %h seen %h", what, exp, seen);
		if (seen !== exp)
			err_count++;
	endtask
	task tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task wait_grant;
		for (int n = 0; n < 40 && gntN === 5'h1F; n++)
			tick(1);
	endtask

	////////////////////////////////////////////////////////////////////
	task reset_check;
		rst_n = 0;
		#1;
		check("oe", {gntOe, holdAckOe, parOe, serrOe, clkrunOe}, 5'h00);
		check("grants", gntN, 5'h1F);
		tick(1);
		rst_n = 1;
		@(posedge mclk);
		#1;
		check("clkrunOe", clkrunOe, 1'h0);
		check("gntOe", gntOe, 1'h1);
		tick(1);
	endtask
	task round_robin;
		logic [4:0] e;
		reqN = 5'h00;
		tick(2);
		check("early", gntN, 5'h1F);
		tick(1);
		for (int k = 0; k < 5; k++)
		begin
			wait_grant;
			e = ~(5'h01 << k);
			check("grant", gntN, e);
			reqN[k] = 1;
			for (int n = 0; n < 9 && gntN === e; n++)
				tick(1);
		end
	endtask
	task hold_seq;
		int n, fw, fp, fh;
		lat = 4'h3;
		reqN = 5'h1D;
		wait_grant;
		bridge_hold_request_n = 0;
		for (n = 1; n < 60 && bridge_hold_ack_n !== 0; n++)
		begin
			tick(1);
			fw = (drainWriteReq && !fw) ? n : fw;
			fp = (drainPostReq && !fp) ? n : fp;
			fh = (hostBusReq && !fh) ? n : fh;
		end
		check("order", {fw > 0, fw < fp, fp < fh, fh < n}, 4'hF);
		check("ack", {bridge_hold_ack_n, holdAckOe, gntN}, 7'h3F);
		tick(2);
		bridge_hold_request_n = 1;
		tick(3);
		check("release", {bridge_hold_ack_n, hostBusReq}, 2'h2);
		wait_grant;
		check("regrant", gntN, 5'h1D);
		reqN = 5'h1F;
		tick(4);
	endtask
	task hold_abort;
		lat = 4'h8;
		bridge_hold_request_n = 0;
		tick(5);
		bridge_hold_request_n = 1;
		tick(12);
		check("abort", {bridge_hold_ack_n, drainWriteReq, drainPostReq,
			hostBusReq}, 4'h8);
	endtask
	task parity_check;
		logic [35:0] v [4];
		v = '{36'h0_0000_0000, 36'h1_0000_0001, 36'hF_FFFF_FFFE,
			36'h8_A5C3_0F11};
		for (int k = 0; k < 4; k++)
		begin
			{cbeOutN, adOut} = v[k];
			parDrive = k[0];
			tick(1);
			check("parOut", parOut, ^v[k]);
			check("parOe", parOe, k[0]);
		end
	endtask
	task serr_check;
		errorEvent = 1;
		tick(1);
		errorEvent = 0;
		check("serr", {serrOe, serrOutN}, 2'h2);
		tick(1);
		check("serrOe", serrOe, 1'h0);
	endtask
	task clkrun_check;
		centralLow = 1;
		tick(4);
		check("seen", {clkrunSeen, clkrunOe}, 2'h2);
		centralLow = 0;
		for (int n = 0; n < 8 && clkrunOe !== 1; n++)
			tick(1);
		check("clkrunOe", {clkrunOe, clkrunOut}, 2'h2);
		keepClock = 0;
		tick(2);
		check("clkrunOff", clkrunOe, 1'h0);
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{rst_n, parDrive, errorEvent, centralLow} = 4'h0;
		{adOut, cbeOutN, lat} = 40'h00_0000_0000;
		reqN = 5'h1F;
		bridge_hold_request_n = 1;
		keepClock = 1;
		tick(5);
		rst_n = 1;
		tick(2);
		reset_check;
		round_robin;
		hold_seq;
		hold_abort;
		parity_check;
		serr_check;
		clkrun_check;
		report_and_stop;
	end
endmodule
